/* File: verilog/ire_codec.sv */
`default_nettype none

module ire_fifo #(
  parameter int WIDTH = 1,
  parameter int DEPTH = 8
) (
  input  wire logic             clk_in,        // system clock
  input  wire logic             rst_n_in,      // sync reset, low
  input  wire logic [WIDTH-1:0] in_data_in,    // write word
  input  wire logic             in_valid_in,   // write offered
  output logic                  in_ready_out,  // room available
  output logic [WIDTH-1:0]      out_data_out,  // head word
  output logic                  out_valid_out, // head valid
  input  wire logic             out_ready_in   // head taken
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL = (AW+1)'(DEPTH);
  // refused at elaboration: pointers wrap only at a power of two
  if (WIDTH < 1 || DEPTH < 2 || (1 << AW) != DEPTH) begin : g_size_chk
    $error("fifo width or depth not supported");
  end
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr_q;
  logic [AW-1:0]    rd_ptr_q;
  logic [AW:0]      cnt_q;
  logic [AW:0]      cnt_d;
  logic             push_w;
  logic             pop_w;

  assign push_w = in_valid_in && in_ready_out;
  assign pop_w  = out_valid_out && out_ready_in;
  assign out_data_out = mem[rd_ptr_q];

  // occupancy; flags are registered so they are honest next cycle
  always_comb begin
    cnt_d = cnt_q;
    if (push_w && !pop_w) cnt_d = cnt_q + (AW+1)'(1);
    if (pop_w && !push_w) cnt_d = cnt_q - (AW+1)'(1);
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      cnt_q         <= '0;
      in_ready_out  <= 1'b1;
      out_valid_out <= 1'b0;
    end else begin
      cnt_q         <= cnt_d;
      in_ready_out  <= cnt_d != FULL;
      out_valid_out <= cnt_d != '0;
    end
  end

  // pointers
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
    end else begin
      if (push_w) wr_ptr_q <= wr_ptr_q + AW'(1);
      if (pop_w)  rd_ptr_q <= rd_ptr_q + AW'(1);
    end
  end

  // storage, no reset needed
  always_ff @(posedge clk_in) begin
    if (push_w) mem[wr_ptr_q] <= in_data_in;
  end
endmodule // ire_fifo
////////////////////////////////////////////////////////////////////////
// How it works
// - enabled: receive pin decoded before reaching UART
// - enabled: encoded pulses replace raw UART transmit
// - neither transmit nor receive starts while the other runs; both can start in the same cycle
// - modulation from UART bits and baud clock
// - each bit lasts sixteen baud ticks
// - a one stays low all bit
// - a zero: low 7, high 3, low 6
// - bit rate is clock over sixteen times divisor
// - standard rates 9600 to 115200, faster allowed
module ire_codec #(
  parameter int FIFO_DEPTH = 8
) (
  input  wire logic        clk_in,          // 200 MHz system clock
  input  wire logic        rst_n_in,        // sync reset, low
  input  wire logic [11:0] reg_addr_in,     // register address
  input  wire logic [7:0]  reg_wdata_in,    // register write data
  input  wire logic        reg_wr_in,       // write strobe
  input  wire logic        reg_rd_in,       // read strobe
  output logic      [7:0]  reg_rdata_out,   // read data, next cycle
  input  wire logic        tx_bit_in,       // UART transmit bit
  input  wire logic        tx_valid_in,     // transmit bit offered
  output logic             tx_ready_out,    // transmit bit room
  input  wire logic        uart_txd_in,     // raw UART transmit line
  output logic             txd_pin_out,     // transmit pin
  input  wire logic        rxd_pin_in,      // receive pin, async
  output logic             uart_rxd_out,    // line to UART receiver
  output logic             baud16_tick_out  // baud clock to UART
);
  if (FIFO_DEPTH < 2) begin : g_depth_chk
    $error("fifo depth too small");
  end
  logic [7:0]   div0_hi_q, div0_lo_q, div1_hi_q, div1_lo_q;
  logic [7:0]   ctrl_q;
  logic         en_w;
  logic [15:0]  div_w, div_eff_w, div_cnt_q;
  logic         tick_w;
  ire_pkg::ire_tx_t tx_st_q;
  ire_pkg::ire_rx_t rx_st_q;
  logic [3:0]   tx_phase_q, rx_phase_q, idle_bits_q;
  logic         tx_bit_q, b_w, pop_w, pulse_w;
  logic         f_data_w, f_valid_w;
  logic         rx_s1_q, rx_s2_q, rx_s3_q, rx_lvl_q;
  logic         rx_pulse_w, seen_q, rx_bit_q, rx_end_w;

  assign en_w = ctrl_q[ire_pkg::CTRL_EN_BIT];
  ////////////////////////////////////////////////////////////////////
  // register writes; unmapped writes are dropped
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      div0_hi_q <= ire_pkg::RST_DIV_HI;
      div0_lo_q <= ire_pkg::RST_DIV_LO;
      div1_hi_q <= ire_pkg::RST_DIV_HI;
      div1_lo_q <= ire_pkg::RST_DIV_LO;
      ctrl_q    <= ire_pkg::RST_CTRL;
    end else if (reg_wr_in) begin
      if (reg_addr_in == ire_pkg::ADR_U0_HI) div0_hi_q <= reg_wdata_in;
      else if (reg_addr_in == ire_pkg::ADR_U0_LO) div0_lo_q <= reg_wdata_in;
      else if (reg_addr_in == ire_pkg::ADR_U1_HI) div1_hi_q <= reg_wdata_in;
      else if (reg_addr_in == ire_pkg::ADR_U1_LO) div1_lo_q <= reg_wdata_in;
      else if (reg_addr_in == ire_pkg::ADR_CTRL)  ctrl_q <= reg_wdata_in;
    end
  end
  // register reads, answered the cycle after the strobe
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      reg_rdata_out <= ire_pkg::RD_UNMAPPED;
    end else if (reg_rd_in) begin
      if (reg_addr_in == ire_pkg::ADR_U0_HI) reg_rdata_out <= div0_hi_q;
      else if (reg_addr_in == ire_pkg::ADR_U0_LO) reg_rdata_out <= div0_lo_q;
      else if (reg_addr_in == ire_pkg::ADR_U1_HI) reg_rdata_out <= div1_hi_q;
      else if (reg_addr_in == ire_pkg::ADR_U1_LO) reg_rdata_out <= div1_lo_q;
      else if (reg_addr_in == ire_pkg::ADR_CTRL)  reg_rdata_out <= ctrl_q;
      else if (reg_addr_in == ire_pkg::ADR_STAT) begin
        reg_rdata_out <= '0;
        reg_rdata_out[ire_pkg::STAT_TX_BIT]  <= tx_st_q == ire_pkg::TX_SEND;
        reg_rdata_out[ire_pkg::STAT_RX_BIT]  <= rx_st_q == ire_pkg::RX_BUSY;
        reg_rdata_out[ire_pkg::STAT_EMP_BIT] <= !f_valid_w;
        reg_rdata_out[ire_pkg::STAT_FUL_BIT] <= !tx_ready_out;
      end else reg_rdata_out <= ire_pkg::RD_UNMAPPED;
    end
  end
  ////////////////////////////////////////////////////////////////////
  // rate generator: one tick per divisor cycles, zero acts as one
  assign div_w = ctrl_q[ire_pkg::CTRL_SEL_BIT] ? {div1_hi_q, div1_lo_q}
                                               : {div0_hi_q, div0_lo_q};
  assign div_eff_w = (div_w == 16'h0000) ? 16'h0001 : div_w;
  assign tick_w = (div_cnt_q + 16'h0001) >= div_eff_w;
  // small divisors give rates beyond the infrared standard
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      div_cnt_q       <= '0;
      baud16_tick_out <= 1'b0;
    end else begin
      div_cnt_q       <= tick_w ? 16'h0000 : div_cnt_q + 16'h0001;
      baud16_tick_out <= tick_w;
    end
  end
  ////////////////////////////////////////////////////////////////////
  // transmit bits queue here; UART stalls when the queue is full
  ire_fifo #(.WIDTH(1), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk_in        (clk_in),
    .rst_n_in      (rst_n_in),
    .in_data_in    (tx_bit_in),
    .in_valid_in   (tx_valid_in),
    .in_ready_out  (tx_ready_out),
    .out_data_out  (f_data_w),
    .out_valid_out (f_valid_w),
    .out_ready_in  (pop_w)
  );
  // a new bit starts only on a tick at a bit boundary
  assign b_w = tick_w && (tx_st_q == ire_pkg::TX_IDLE ||
                          tx_phase_q == ire_pkg::PHASE_LAST);
  // no new bit while a reception is running
  assign pop_w = b_w && en_w && f_valid_w &&
                 rx_st_q == ire_pkg::RX_IDLE;
  // zero bits pulse high in ticks 7..9, ones never
  assign pulse_w = tx_st_q == ire_pkg::TX_SEND && !tx_bit_q &&
                   tx_phase_q >= ire_pkg::PULSE_START &&
                   tx_phase_q <  ire_pkg::PULSE_END;

  // encoder state machine, sixteen ticks per bit
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      tx_st_q    <= ire_pkg::TX_IDLE;
      tx_phase_q <= '0;
      tx_bit_q   <= 1'b1;
    end else begin
      case (tx_st_q)
        ire_pkg::TX_IDLE: begin
          if (pop_w) begin
            tx_st_q    <= ire_pkg::TX_SEND;
            tx_phase_q <= '0;
            tx_bit_q   <= f_data_w;
          end
        end
        ire_pkg::TX_SEND: begin
          if (pop_w) begin
            tx_phase_q <= '0;
            tx_bit_q   <= f_data_w;
          end else if (b_w) begin
            tx_st_q    <= ire_pkg::TX_IDLE;
            tx_phase_q <= '0;
          end else if (tick_w) begin
            tx_phase_q <= tx_phase_q + 4'h1;
          end
        end
        default: tx_st_q <= ire_pkg::TX_IDLE;
      endcase
    end
  end
  // pin mux; a one-cycle delay keeps the pin on a flop
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) txd_pin_out <= 1'b0;
    else txd_pin_out <= en_w ? pulse_w : uart_txd_in;
  end
  ////////////////////////////////////////////////////////////////////
  // receive pin synchroniser; level moves once stages 2 and 3 agree
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      rx_s1_q  <= 1'b0;
      rx_s2_q  <= 1'b0;
      rx_s3_q  <= 1'b0;
      rx_lvl_q <= 1'b0;
    end else begin
      rx_s1_q <= rxd_pin_in;
      rx_s2_q <= rx_s1_q;
      rx_s3_q <= rx_s2_q;
      if (rx_s2_q == rx_s3_q) rx_lvl_q <= rx_s3_q;
    end
  end
  // our own echo is ignored while sending
  assign rx_pulse_w = en_w && rx_lvl_q && tx_st_q == ire_pkg::TX_IDLE;
  assign rx_end_w = rx_st_q == ire_pkg::RX_BUSY && tick_w &&
                    rx_phase_q == ire_pkg::PHASE_LAST;

  // decoder: window aligned to first pulse, idle after quiet bits
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      rx_st_q     <= ire_pkg::RX_IDLE;
      rx_phase_q  <= '0;
      idle_bits_q <= '0;
      seen_q      <= 1'b0;
      rx_bit_q    <= 1'b1;
    end else begin
      case (rx_st_q)
        ire_pkg::RX_IDLE: begin
          rx_bit_q <= 1'b1;
          if (rx_pulse_w) begin
            rx_st_q     <= ire_pkg::RX_BUSY;
            rx_phase_q  <= ire_pkg::RX_ALIGN;
            idle_bits_q <= '0;
            seen_q      <= 1'b1;
          end
        end
        ire_pkg::RX_BUSY: begin
          if (rx_end_w) begin
            rx_bit_q   <= !seen_q;
            seen_q     <= rx_pulse_w;
            rx_phase_q <= '0;
            if (seen_q) idle_bits_q <= '0;
            else idle_bits_q <= idle_bits_q + 4'h1;
            if (!seen_q && idle_bits_q + 4'h1 >= ire_pkg::RX_HOLD_BITS)
              rx_st_q <= ire_pkg::RX_IDLE;
          end else begin
            if (rx_pulse_w) seen_q <= 1'b1;
            if (tick_w) rx_phase_q <= rx_phase_q + 4'h1;
          end
        end
        default: rx_st_q <= ire_pkg::RX_IDLE;
      endcase
    end
  end
  // line to UART: decoded when enabled, raw pin otherwise
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) uart_rxd_out <= 1'b1;
    else uart_rxd_out <= en_w ? rx_bit_q : rx_lvl_q;
  end
  ////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  logic [15:0] since_q;
  logic        div_chg_q;
  always_ff @(posedge clk_in) begin
    if (!rst_n_in || tick_w) begin
      since_q   <= '0;
      div_chg_q <= 1'b0;
    end else begin
      since_q   <= since_q + 16'h0001;
      if (div_w != $past(div_w)) div_chg_q <= 1'b1;
    end
  end

  property p_rx_route;
    en_w && $stable(en_w) |=> uart_rxd_out == $past(rx_bit_q);
  endproperty
  a_rx_route: assert property (p_rx_route)
    else $error("receive line not from decoder");
  property p_tx_route;
    en_w && $past(en_w) |-> txd_pin_out == $past(pulse_w);
  endproperty
  a_tx_route: assert property (p_tx_route)
    else $error("transmit pin not from encoder");
  property p_half;
    rx_st_q == ire_pkg::RX_BUSY |-> !pop_w;
  endproperty
  a_half: assert property (p_half)
    else $error("transmit started during reception");
  property p_pop_tick;
    pop_w |-> tick_w ##1 tx_st_q == ire_pkg::TX_SEND && tx_phase_q == 4'h0;
  endproperty
  a_pop_tick: assert property (p_pop_tick)
    else $error("bit taken off the baud clock");
  property p_bit_len;
    tx_st_q == ire_pkg::TX_SEND && tick_w && tx_phase_q == 4'hE
      |=> tx_phase_q == ire_pkg::PHASE_LAST;
  endproperty
  a_bit_len: assert property (p_bit_len)
    else $error("bit period not sixteen ticks");
  property p_one_low;
    tx_st_q == ire_pkg::TX_SEND && tx_bit_q |-> !pulse_w;
  endproperty
  a_one_low: assert property (p_one_low)
    else $error("pulse during a one");
  property p_zero_shape;
    $rose(pulse_w) |-> tx_phase_q == 4'h7 ##0 !tx_bit_q;
  endproperty
  a_zero_shape: assert property (p_zero_shape)
    else $error("zero pulse misplaced");
  property p_zero_end;
    $fell(pulse_w) && tx_st_q == ire_pkg::TX_SEND |-> tx_phase_q == 4'hA;
  endproperty
  a_zero_end: assert property (p_zero_end)
    else $error("zero pulse wrong length");
  // a divisor write disturbs the spacing, so that tick is skipped
  property p_rate;
    tick_w && !div_chg_q && $stable(div_w) && $past(tick_w) == 1'b0
      |-> since_q + 16'h0001 == div_eff_w;
  endproperty
  a_rate: assert property (p_rate)
    else $error("tick spacing not divisor");
  property p_decode;
    rx_end_w && seen_q |=> !rx_bit_q;
  endproperty
  a_decode: assert property (p_decode)
    else $error("pulse not decoded as zero");
  c_send_zero: cover property (pop_w && !f_data_w);
  c_send_one:  cover property (pop_w && f_data_w);
  c_rx_zero:   cover property (rx_end_w && seen_q);
  c_fifo_full: cover property (!tx_ready_out && tx_valid_in);
endmodule // ire_codec

`default_nettype wire

/* File: verilog/ire_pkg.sv */
`default_nettype none
package ire_pkg;
  // register addresses on the plain register port
  localparam logic [11:0] ADR_U0_HI = 12'hF46;
  localparam logic [11:0] ADR_U0_LO = 12'hF47;
  localparam logic [11:0] ADR_U1_HI = 12'hF4E;
  localparam logic [11:0] ADR_U1_LO = 12'hF4F;
  localparam logic [11:0] ADR_CTRL  = 12'hF50;
  localparam logic [11:0] ADR_STAT  = 12'hF51;
  // reset values
  localparam logic [7:0] RST_DIV_LO = 8'hFF;
  localparam logic [7:0] RST_DIV_HI = 8'h00;
  localparam logic [7:0] RST_CTRL   = 8'h00;
  localparam logic [7:0] RD_UNMAPPED = 8'h00;
  // control and status field positions
  localparam int CTRL_EN_BIT  = 0;
  localparam int CTRL_SEL_BIT = 1;
  localparam int STAT_TX_BIT  = 0;
  localparam int STAT_RX_BIT  = 1;
  localparam int STAT_EMP_BIT = 2;
  localparam int STAT_FUL_BIT = 3;
  // bit timing in baud ticks; receive hold counted in bits
  localparam logic [3:0] PHASE_LAST  = 4'hF;
  localparam logic [3:0] PULSE_START = 4'h7;
  localparam logic [3:0] PULSE_END   = 4'hA;
  localparam logic [3:0] RX_ALIGN    = 4'h7;
  localparam logic [3:0] RX_HOLD_BITS = 4'hA;
  typedef enum logic [0:0] {TX_IDLE = 1'b0, TX_SEND = 1'b1} ire_tx_t;
  typedef enum logic [0:0] {RX_IDLE = 1'b0, RX_BUSY = 1'b1} ire_rx_t;
endpackage
`default_nettype wire

/* File: verification/ire_xcvr_model.sv */
`default_nettype none
////////////////////////////////////////////////////////////////////////
// behavioural infrared transceiver on the far side of the pins
module ire_xcvr_model (
  input  wire logic clk_in,    // system clock
  input  wire logic tick_in,   // baud x16 tick from the device
  input  wire logic ir_tx_in,  // encoded transmit pin
  output logic      ir_rx_out  // detected light, low when dark
);
  timeunit 1ns;
  timeprecision 1ps;
  int pulse_count;

  // dark line at start: no light means low
  initial begin
    ir_rx_out = 1'b0;
    pulse_count = 0;
  end

  // each rising edge of the emitter is one light pulse
  always @(posedge ir_tx_in) begin
    pulse_count <= pulse_count + 1;
  end

  // a zero bit as light: three ticks high on tick edges
  // caller only sends while the device is quiet, half duplex
  task automatic send_zero();
    @(posedge clk_in iff tick_in);
    ir_rx_out <= 1'b1;
    repeat (3) @(posedge clk_in iff tick_in);
    ir_rx_out <= 1'b0;
  endtask
endmodule // ire_xcvr_model
`default_nettype wire

/* File: verification/infrared_endec_baud_gen_tb.sv */
`default_nettype none
module infrared_endec_baud_gen_tb;
  timeunit 1ns;
  timeprecision 1ps;
  // small divisor keeps each bit at 48 cycles
  localparam logic [7:0] DIV = 8'h03;
  logic        clk_in;
  logic        rst_n_in = 1'b0;
  logic [11:0] reg_addr_in = 12'h000;
  logic [7:0]  reg_wdata_in = 8'h00;
  logic        reg_wr_in = 1'b0;
  logic        reg_rd_in = 1'b0;
  logic [7:0]  reg_rdata_out;
  logic        tx_bit_in = 1'b0;
  logic        tx_valid_in = 1'b0;
  logic        tx_ready_out;
  logic        uart_txd_in = 1'b1;
  logic        txd_pin_out;
  logic        rxd_pin_in;
  logic        uart_rxd_out;
  logic        baud16_tick_out;
  int          fails = 0;
  int          check_count = 0;
  int          cyc = 0;
  int          n;
  int          t1;
  int          t2;
  int          base;

  ire_codec i_dut (.clk_in(clk_in), .rst_n_in(rst_n_in),
    .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
    .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
    .reg_rdata_out(reg_rdata_out), .tx_bit_in(tx_bit_in),
    .tx_valid_in(tx_valid_in), .tx_ready_out(tx_ready_out),
    .uart_txd_in(uart_txd_in), .txd_pin_out(txd_pin_out),
    .rxd_pin_in(rxd_pin_in), .uart_rxd_out(uart_rxd_out),
    .baud16_tick_out(baud16_tick_out));
  ire_xcvr_model i_xcvr (.clk_in(clk_in), .tick_in(baud16_tick_out),
    .ir_tx_in(txd_pin_out), .ir_rx_out(rxd_pin_in));

  ////////////////////////////////////////////////////////////////////////
  // clock and cycle count
  initial begin
    clk_in = 1'b0;
    forever #2.5 clk_in = ~clk_in;
  end
  always @(posedge clk_in) cyc <= cyc + 1;

  task automatic test_done();
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp,
                     input string what);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("ERROR %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask

  // one-cycle write strobe, gap of one cycle before the next access
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge clk_in);
    reg_addr_in <= a;
    reg_wdata_in <= d;
    reg_wr_in <= 1'b1;
    @(posedge clk_in);
    reg_wr_in <= 1'b0;
  endtask

  // read data appear the cycle after the strobe and hold until the next read
  task automatic rd_chk(input logic [11:0] a, input logic [7:0] m,
                        input logic [7:0] exp, input string what);
    @(posedge clk_in);
    reg_addr_in <= a;
    reg_rd_in <= 1'b1;
    @(posedge clk_in);
    reg_rd_in <= 1'b0;
    #1;
    chk(reg_rdata_out & m, exp, what);
  endtask

  // offer a bit and hold it until ready is seen at an edge
  task automatic push(input logic b);
    @(posedge clk_in);
    tx_bit_in <= b;
    tx_valid_in <= 1'b1;
    @(posedge clk_in iff tx_ready_out === 1'b1);
    tx_valid_in <= 1'b0;
  endtask

  // start cycle and width of the next light pulse on the pin
  task automatic next_pulse(output int at, output int width);
    int lim;
    lim = 0;
    width = 0;
    while (txd_pin_out !== 1'b1 && lim < 400) begin
      @(posedge clk_in);
      #1;
      lim++;
    end
    at = cyc;
    while (txd_pin_out === 1'b1 && width < 400) begin
      @(posedge clk_in);
      #1;
      width++;
    end
  endtask

  ////////////////////////////////////////////////////////////////////////
  // watchdog: whole sequence needs about 1800 cycles
  initial begin
    repeat (20000) @(posedge clk_in);
    fails++;
    $display("ERROR %0t: watchdog expired", $time);
    test_done();
  end

  initial begin
    repeat (6) @(posedge clk_in);
    rst_n_in <= 1'b1;
    // reset values, read-write access, unmapped read
    rd_chk(ire_pkg::ADR_U0_LO, 8'hFF, 8'hFF, "u0 low");
    rd_chk(ire_pkg::ADR_U1_LO, 8'hFF, 8'hFF, "u1 low");
    rd_chk(ire_pkg::ADR_U0_HI, 8'hFF, 8'h00, "u0 high");
    rd_chk(12'h123, 8'hFF, 8'h00, "unmapped");
    wr(ire_pkg::ADR_U1_LO, 8'h5A);
    rd_chk(ire_pkg::ADR_U1_LO, 8'hFF, 8'h5A, "u1 low rw");
    $display("test registers done");
    // disabled: raw uart line reaches the pin, ends idle high
    for (n = 0; n < 2; n++) begin
      @(posedge clk_in);
      uart_txd_in <= n[0];
      repeat (2) @(posedge clk_in);
      #1;
      chk({7'h00, txd_pin_out}, {7'h00, n[0]}, "raw pin");
    end
    $display("test passthrough done");
    // queue fills while disabled; ready drops once eight bits are held
    repeat (8) push(1'b1);
    #1;
    chk({7'h00, tx_ready_out}, 8'h00, "queue ready");
    rd_chk(ire_pkg::ADR_STAT, 8'h0C, 8'h08, "full");
    // divisor rounded from clock over 16 x rate
    wr(ire_pkg::ADR_U0_LO, DIV);
    wr(ire_pkg::ADR_U0_HI, 8'h00);
    wr(ire_pkg::ADR_CTRL, 8'h01);
    // raw-mode highs already lit the emitter; count from here on
    base = i_xcvr.pulse_count;
    n = 0;
    repeat (96) begin
      @(posedge clk_in);
      #1;
      if (baud16_tick_out === 1'b1) n++;
    end
    chk(8'(n), 8'h20, "ticks in 96");
    // enabled with idle uart high: pin stays dark for ones
    chk({7'h00, txd_pin_out}, 8'h00, "pin dark");
    repeat (450) @(posedge clk_in);
    rd_chk(ire_pkg::ADR_STAT, 8'h04, 8'h04, "drained");
    chk(8'(i_xcvr.pulse_count - base), 8'h00, "ones dark");
    $display("test queue done");
    // zero, one, zero: pulse 3 ticks, rise to rise two bits
    push(1'b0);
    push(1'b1);
    push(1'b0);
    next_pulse(t1, n);
    chk(8'(n), 8'h09, "pulse width");
    next_pulse(t2, n);
    chk(8'(n), 8'h09, "pulse width");
    chk(8'(t2 - t1), 8'h60, "bit spacing");
    chk(8'(i_xcvr.pulse_count - base), 8'h02, "pulses");
    $display("test transmit done");
    // receive a zero, then a queued bit must wait for quiet
    repeat (60) @(posedge clk_in);
    chk({7'h00, uart_rxd_out}, 8'h01, "rx idle");
    i_xcvr.send_zero();
    n = 0;
    while (uart_rxd_out !== 1'b0 && n < 80) begin
      @(posedge clk_in);
      #1;
      n++;
    end
    chk({7'h00, uart_rxd_out}, 8'h00, "rx zero");
    rd_chk(ire_pkg::ADR_STAT, 8'h02, 8'h02, "rx busy");
    push(1'b0);
    repeat (100) @(posedge clk_in);
    chk(8'(i_xcvr.pulse_count - base), 8'h02, "no tx in rx");
    repeat (700) @(posedge clk_in);
    #1;
    chk(8'(i_xcvr.pulse_count - base), 8'h03, "tx after rx");
    chk({7'h00, uart_rxd_out}, 8'h01, "rx back idle");
    $display("test receive done");
    // second divisor selected: one tick every two cycles
    wr(ire_pkg::ADR_U1_LO, 8'h02);
    wr(ire_pkg::ADR_CTRL, 8'h03);
    n = 0;
    repeat (96) begin
      @(posedge clk_in);
      #1;
      if (baud16_tick_out === 1'b1) n++;
    end
    chk(8'(n), 8'h30, "ticks divisor one");
    $display("test divisor select done");
    test_done();
  end
endmodule // infrared_endec_baud_gen_tb
`default_nettype wire
